//--- cal_pkg.sv
// constants shared by the concentration alarm logic
package cal_pkg;

	// register byte offsets on the avalon slave
	localparam logic [4:0] CAL_OFF_CTRL = 5'h00;
	localparam logic [4:0] CAL_OFF_ALARM1 = 5'h04;
	localparam logic [4:0] CAL_OFF_ALARM2 = 5'h08;
	localparam logic [4:0] CAL_OFF_STATE = 5'h0C;
	localparam logic [4:0] CAL_OFF_IRQ_STATUS = 5'h10;
	localparam logic [4:0] CAL_OFF_IRQ_ENABLE = 5'h14;
	localparam logic [4:0] CAL_OFF_IRQ_CLEAR = 5'h18;
	localparam logic [4:0] CAL_OFF_CONC = 5'h1C;

	// control register fields
	localparam int CAL_CTRL_PCT_BIT = 0;

	// alarm configuration register fields
	localparam int CAL_CFG_SP_LSB = 0;
	localparam int CAL_CFG_SP_W = 16;
	localparam int CAL_CFG_RISING_BIT = 16;
	localparam int CAL_CFG_DEFEAT_BIT = 17;
	localparam int CAL_CFG_FAILSAFE_BIT = 18;
	localparam int CAL_CFG_LATCH_BIT = 19;
	localparam logic [31:0] CAL_CFG_MASK = 32'h000FFFFF;

	// state register fields
	localparam int CAL_ST_ACTIVE1_BIT = 0;
	localparam int CAL_ST_ACTIVE2_BIT = 1;
	localparam int CAL_ST_RELAY1_BIT = 2;
	localparam int CAL_ST_RELAY2_BIT = 3;
	localparam int CAL_ST_SYSRELAY_BIT = 4;
	localparam int CAL_ST_PCT_BIT = 5;

	// interrupt event bits, same layout in status, enable and clear
	localparam int CAL_IRQ_ALARM1_BIT = 0;
	localparam int CAL_IRQ_ALARM2_BIT = 1;
	localparam int CAL_IRQ_SYSFAIL_BIT = 2;
	localparam int CAL_IRQ_W = 3;

	// reset values
	localparam logic [31:0] CAL_RST_CTRL = 32'h00000000;
	localparam logic [31:0] CAL_RST_CFG = 32'h00000000;
	localparam logic [2:0] CAL_RST_IRQ_EN = 3'h0;

	// one percent expressed in ppm counts
	localparam logic [31:0] CAL_PPM_PER_PCT = 32'h00002710;

	// number of concentration alarms
	localparam int CAL_NUM_ALARMS = 2;

endpackage : cal_pkg

//--- cal_chan_if.sv
// link between the alarm control logic and one alarm channel
`timescale 1ns/1ps
`default_nettype none
interface cal_chan_if;
	logic [31:0] limit; // setpoint already scaled to ppm counts
	logic rising; // 1 = rising_direction, 0 = falling_direction
	logic defeat; // alarm suppressed
	logic failsafe_flag; // relay de-energized in alarm
	logic latch; // latching alarm
	logic [31:0] sample; // concentration in ppm counts
	logic sample_valid; // new sample strobe
	logic active; // alarm condition present
	logic relay; // relay coil drive
	logic trip_evt; // one-cycle pulse when alarm becomes active

	modport ctrl (
		output limit, rising, defeat, failsafe_flag, latch, sample, sample_valid,
		input active, relay, trip_evt
	);
	modport unit (
		input limit, rising, defeat, failsafe_flag, latch, sample, sample_valid,
		output active, relay, trip_evt
	);
endinterface : cal_chan_if
`default_nettype wire

//--- cal_alarm_unit.sv
// one concentration alarm channel: compare, latch, defeat and relay drive
`timescale 1ns/1ps
`default_nettype none
module cal_alarm_unit
	import cal_pkg::*;
(
	input wire logic clk_in, // system clock
	input wire logic rstn_in, // synchronous reset, active low
	cal_chan_if.unit chan // configuration in, alarm state out
);

	logic trip_q; // last comparison result
	logic latched_q; // held alarm for latching mode
	logic active_prev_q; // for the activation edge
	logic relay_q;
	logic active_d;
	logic trip_now;

	// comparison of the new sample against the scaled setpoint
	always_comb begin
		if (chan.rising) begin
			trip_now = chan.sample > chan.limit;
		end else begin
			trip_now = chan.sample < chan.limit;
		end
	end

	// comparison is refreshed only when a new sample arrives
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			trip_q <= 1'b0;
		end else if (chan.sample_valid) begin
			trip_q <= trip_now;
		end
	end

	// latch store; defeat or dropping the latch option wipes it, so the
	// operator's toggle of either option clears a held alarm
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			latched_q <= 1'b0;
		end else if (chan.defeat) begin
			latched_q <= 1'b0;
		end else if (!chan.latch) begin
			latched_q <= 1'b0;
		end else if (chan.sample_valid && trip_now) begin
			latched_q <= 1'b1;
		end
	end

	// defeat masks everything; without latch only the live comparison counts
	always_comb begin
		active_d = !chan.defeat && (trip_q || latched_q);
	end

	// relay polarity follows the failsafe option, registered
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			relay_q <= 1'b0;
			active_prev_q <= 1'b0;
		end else begin
			relay_q <= active_d ^ chan.failsafe_flag;
			active_prev_q <= active_d;
		end
	end

	assign chan.active = active_prev_q;
	assign chan.relay = relay_q;
	assign chan.trip_evt = active_d && !active_prev_q;

endmodule : cal_alarm_unit
`default_nettype wire

//--- cal_alarm_top.sv
// concentration alarm logic with avalon register access and interrupt
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - two independent alarms, each with own setpoint and own relay output
// - rising direction alarms when concentration rises above the setpoint
// - falling direction alarms when concentration falls below the setpoint
// - failsafe alarm de-energizes its relay in alarm, energized otherwise
// - non-failsafe alarm energizes its relay in alarm, de-energized otherwise
// - latching alarm stays active after the process returns, until reset
// - non-latching alarm ends as soon as the comparison no longer trips
// - defeat suppresses the alarm so trip conditions do not activate it
// - setting then clearing defeat resets a latched alarm
// - clearing then setting latch also resets a latched alarm
// - separate system failure alarm relay with fixed configuration
// - setpoints are in a selectable unit, percent or ppm
// - detector balance failure during zeroing raises the system failure alarm
module cal_alarm_top
	import cal_pkg::*;
(
	input wire logic clk_in, // system clock, 10 MHz
	input wire logic rstn_in, // synchronous reset, active low
	input wire logic [4:0] avs_address_in, // byte address
	input wire logic avs_read_in, // read request
	input wire logic avs_write_in, // write request
	input wire logic [3:0] avs_byteenable_in, // write byte lanes
	input wire logic [31:0] avs_writedata_in, // write data
	output logic [31:0] avs_readdata_out, // read data, registered
	output logic avs_waitrequest_out, // stall the master
	input wire logic [31:0] conc_in, // measured concentration, ppm counts
	input wire logic conc_valid_in, // one-cycle new sample strobe
	input wire logic balance_fail_in, // detector cannot be balanced, level
	output logic alarm1_relay_out, // first alarm relay coil
	output logic alarm2_relay_out, // second alarm relay coil
	output logic sys_fail_relay_out, // system failure relay coil
	output logic irq_out // level interrupt, registered
);

	// scales a setpoint to ppm counts according to the unit choice
	function automatic logic [31:0] cal_scale(input logic [15:0] sp, input logic pct);
		logic [31:0] wide;
		wide = {16'h0000, sp};
		if (pct) begin
			cal_scale = wide * CAL_PPM_PER_PCT;
		end else begin
			cal_scale = wide;
		end
	endfunction : cal_scale

	// merges write data into a register under the byte enables
	function automatic logic [31:0] cal_merge(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		cal_merge = res;
	endfunction : cal_merge

	logic ack_q; // second cycle of a bus access
	logic req;
	logic wr_go;
	logic rd_go;
	logic [31:0] rdata_q;
	logic [31:0] ctrl_q;
	logic [31:0] cfg_q [CAL_NUM_ALARMS];
	logic [31:0] conc_q;
	logic [CAL_IRQ_W-1:0] irq_status_q;
	logic [CAL_IRQ_W-1:0] irq_en_q;
	logic [CAL_IRQ_W-1:0] irq_clr;
	logic [CAL_IRQ_W-1:0] irq_evt;
	logic irq_q;
	logic sys_relay_q;
	logic sys_fail_q;
	logic [31:0] state_word;
	logic [CAL_NUM_ALARMS-1:0] chan_active;
	logic [CAL_NUM_ALARMS-1:0] chan_relay;
	logic [CAL_NUM_ALARMS-1:0] chan_evt;

	// every access takes one wait cycle; the edge with waitrequest low
	// commits the write and presents the read data
	assign req = avs_read_in || avs_write_in;
	assign avs_waitrequest_out = req && !ack_q;
	assign wr_go = avs_write_in && ack_q;
	assign rd_go = avs_read_in && !ack_q;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q;
		end
	end

	// unit selection for all setpoints
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			ctrl_q <= CAL_RST_CTRL;
		end else if (wr_go && avs_address_in == CAL_OFF_CTRL) begin
			ctrl_q <= cal_merge(ctrl_q, avs_writedata_in, avs_byteenable_in) & 32'h00000001;
		end
	end

	// per-alarm setpoint and option bits
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			cfg_q[0] <= CAL_RST_CFG;
			cfg_q[1] <= CAL_RST_CFG;
		end else if (wr_go) begin
			if (avs_address_in == CAL_OFF_ALARM1) begin
				cfg_q[0] <= cal_merge(cfg_q[0], avs_writedata_in, avs_byteenable_in) & CAL_CFG_MASK;
			end
			if (avs_address_in == CAL_OFF_ALARM2) begin
				cfg_q[1] <= cal_merge(cfg_q[1], avs_writedata_in, avs_byteenable_in) & CAL_CFG_MASK;
			end
		end
	end

	// last sample kept for software to read
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			conc_q <= 32'h00000000;
		end else if (conc_valid_in) begin
			conc_q <= conc_in;
		end
	end

	// two alarm channels, each with its own setpoint and relay
	cal_chan_if chan [CAL_NUM_ALARMS] ();

	for (genvar g = 0; g < CAL_NUM_ALARMS; g++) begin : g_alarm
		assign chan[g].limit = cal_scale(cfg_q[g][CAL_CFG_SP_LSB +: CAL_CFG_SP_W],
			ctrl_q[CAL_CTRL_PCT_BIT]);
		assign chan[g].rising = cfg_q[g][CAL_CFG_RISING_BIT];
		assign chan[g].defeat = cfg_q[g][CAL_CFG_DEFEAT_BIT];
		assign chan[g].failsafe_flag = cfg_q[g][CAL_CFG_FAILSAFE_BIT];
		assign chan[g].latch = cfg_q[g][CAL_CFG_LATCH_BIT];
		assign chan[g].sample = conc_in;
		assign chan[g].sample_valid = conc_valid_in;
		assign chan_active[g] = chan[g].active;
		assign chan_relay[g] = chan[g].relay;
		assign chan_evt[g] = chan[g].trip_evt;

		cal_alarm_unit u_unit (
			.clk_in(clk_in),
			.rstn_in(rstn_in),
			.chan(chan[g])
		);
	end

	// system failure relay is always failsafe and non-latching; during
	// reset the coil is dropped, which reads as an alarm on purpose
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			sys_fail_q <= 1'b0;
			sys_relay_q <= 1'b0;
		end else begin
			sys_fail_q <= balance_fail_in;
			sys_relay_q <= !balance_fail_in;
		end
	end

	assign alarm1_relay_out = chan_relay[0];
	assign alarm2_relay_out = chan_relay[1];
	assign sys_fail_relay_out = sys_relay_q;

	// interrupt events: alarm activation edges and system failure onset
	assign irq_evt[CAL_IRQ_ALARM1_BIT] = chan_evt[0];
	assign irq_evt[CAL_IRQ_ALARM2_BIT] = chan_evt[1];
	assign irq_evt[CAL_IRQ_SYSFAIL_BIT] = balance_fail_in && !sys_fail_q;

	always_comb begin
		irq_clr = '0;
		if (wr_go && avs_address_in == CAL_OFF_IRQ_CLEAR && avs_byteenable_in[0]) begin
			irq_clr = avs_writedata_in[CAL_IRQ_W-1:0];
		end
	end

	// sticky status; a new event in the clearing cycle survives
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= (irq_status_q & ~irq_clr) | irq_evt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			irq_en_q <= CAL_RST_IRQ_EN;
		end else if (wr_go && avs_address_in == CAL_OFF_IRQ_ENABLE && avs_byteenable_in[0]) begin
			irq_en_q <= avs_writedata_in[CAL_IRQ_W-1:0];
		end
	end

	// registered so the pin is glitch free; lags status by one cycle
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_status_q & irq_en_q);
		end
	end

	assign irq_out = irq_q;

	// live view of alarm and relay state
	always_comb begin
		state_word = 32'h00000000;
		state_word[CAL_ST_ACTIVE1_BIT] = chan_active[0];
		state_word[CAL_ST_ACTIVE2_BIT] = chan_active[1];
		state_word[CAL_ST_RELAY1_BIT] = chan_relay[0];
		state_word[CAL_ST_RELAY2_BIT] = chan_relay[1];
		state_word[CAL_ST_SYSRELAY_BIT] = sys_relay_q;
		state_word[CAL_ST_PCT_BIT] = ctrl_q[CAL_CTRL_PCT_BIT];
	end

	// read mux, loaded in the wait cycle; unmapped and clear read zero
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			rdata_q <= 32'h00000000;
		end else if (rd_go) begin
			case (avs_address_in)
				CAL_OFF_CTRL: rdata_q <= ctrl_q;
				CAL_OFF_ALARM1: rdata_q <= cfg_q[0];
				CAL_OFF_ALARM2: rdata_q <= cfg_q[1];
				CAL_OFF_STATE: rdata_q <= state_word;
				CAL_OFF_IRQ_STATUS: rdata_q <= {29'h00000000, irq_status_q};
				CAL_OFF_IRQ_ENABLE: rdata_q <= {29'h00000000, irq_en_q};
				CAL_OFF_CONC: rdata_q <= conc_q;
				default: rdata_q <= 32'h00000000;
			endcase
		end
	end

	assign avs_readdata_out = rdata_q;

endmodule : cal_alarm_top
`default_nettype wire

//--- cal_alarm_checker.sv
// port-level assertions for the concentration alarm block
`timescale 1ns/1ps
`default_nettype none
module cal_alarm_checker (
	input wire logic clk_in, // system clock
	input wire logic rstn_in, // sync reset, active low
	input wire logic avs_read_in, // read request
	input wire logic avs_write_in, // write request
	input wire logic [31:0] avs_readdata_out, // read data
	input wire logic avs_waitrequest_out, // stall
	input wire logic conc_valid_in, // sample strobe
	input wire logic balance_fail_in, // balance fault level
	input wire logic alarm1_relay_out, // relay 1
	input wire logic alarm2_relay_out, // relay 2
	input wire logic sys_fail_relay_out, // system relay
	input wire logic irq_out // interrupt
);
	logic [3:0] cause_q;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// recent samples, writes, faults or resets; outputs may only move after one
	always_ff @(posedge clk_in) begin
		cause_q <= {cause_q[2:0], conc_valid_in | avs_write_in | balance_fail_in | !rstn_in};
	end
	sequence req_rise;
		$rose(avs_read_in | avs_write_in);
	endsequence
	sequence one_wait;
		avs_waitrequest_out ##1 !avs_waitrequest_out;
	endsequence
	wait_one_a: assert property (req_rise |-> one_wait)
		else $error("access did not take one wait state");
	idle_free_a: assert property (!(avs_read_in | avs_write_in) |-> !avs_waitrequest_out)
		else $error("stall without a request");
	hold_data_a: assert property (!avs_read_in |=> $stable(avs_readdata_out))
		else $error("read data moved without a read");
	reset_quiet_a: assert property ($rose(rstn_in) |-> !alarm1_relay_out &&
		!alarm2_relay_out && !sys_fail_relay_out && !irq_out)
		else $error("outputs not quiet after reset");
	sys_trip_a: assert property (balance_fail_in |=> !sys_fail_relay_out)
		else $error("system relay stayed energized on fault");
	// sampled reset in the antecedent: the release edge itself still drops the coil
	sys_ok_a: assert property (rstn_in && !balance_fail_in |=> sys_fail_relay_out)
		else $error("system relay dropped without fault");
	relay1_cause_a: assert property ($changed(alarm1_relay_out) |-> |cause_q)
		else $error("relay 1 moved without cause");
	relay2_cause_a: assert property ($changed(alarm2_relay_out) |-> |cause_q)
		else $error("relay 2 moved without cause");
	irq_cause_a: assert property ($rose(irq_out) |-> |cause_q)
		else $error("interrupt rose without cause");
endmodule : cal_alarm_checker
bind cal_alarm_top cal_alarm_checker u_cal_alarm_checker (.clk_in, .rstn_in, .avs_read_in,
	.avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .conc_valid_in,
	.balance_fail_in, .alarm1_relay_out, .alarm2_relay_out, .sys_fail_relay_out, .irq_out);
`default_nettype wire

//--- cal_coil_model.sv
// relay coil model on the far side of the drive outputs
`timescale 1ns/1ps
`default_nettype none
module cal_coil_model (
	input wire logic clk_in, // system clock
	input wire logic [2:0] drive_in, // coil drives
	output logic [2:0] coil_out // armature state
);
	// armature pulls in one clock late, like a slow relay
	always_ff @(posedge clk_in) begin
		coil_out <= drive_in;
	end
endmodule : cal_coil_model
`default_nettype wire

//--- concentration_alarm_logic_test.sv
// self-checking bench for the concentration alarm block
`timescale 1ns/1ps
`default_nettype none
module concentration_alarm_logic_test
	import cal_pkg::*;
;
	logic clk_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out, conc_valid_in;
	logic balance_fail_in, alarm1_relay_out, alarm2_relay_out, sys_fail_relay_out, irq_out;
	logic [4:0] avs_address_in;
	logic [3:0] avs_byteenable_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, conc_in;
	logic [2:0] coil;
	int err_total, checks;
	cal_alarm_top u_cal_alarm_top (.clk_in, .rstn_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out,
		.avs_waitrequest_out, .conc_in, .conc_valid_in, .balance_fail_in,
		.alarm1_relay_out, .alarm2_relay_out, .sys_fail_relay_out, .irq_out);
	cal_coil_model u_cal_coil_model (.clk_in, .drive_in({sys_fail_relay_out,
		alarm2_relay_out, alarm1_relay_out}), .coil_out(coil));
	// 10 MHz system clock
	always #50 clk_in = ~clk_in;
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask : tick
	// one avalon access; request held until the edge that sees no stall
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= !w;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'h0 && n < 50);
		if (avs_waitrequest_out !== 1'h0) begin
			err_total++;
			give_verdict();
		end
		q = avs_readdata_out;
		avs_write_in <= 1'h0;
		avs_read_in <= 1'h0;
		// one idle edge so a following access never re-drives in this step
		@(posedge clk_in);
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
	endtask : wr
	task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'h0, a, 32'h0, q);
		chk(nm, e, q);
	endtask : rdc
	// one sample strobe, then time for relay and interrupt to settle
	task automatic samp(input logic [31:0] v);
		conc_in <= v;
		conc_valid_in <= 1'h1;
		@(posedge clk_in);
		conc_valid_in <= 1'h0;
		tick(3);
	endtask : samp
	// mode nibble: 1 rising, 2 defeat, 4 failsafe, 8 latch
	function automatic logic [31:0] cf(input logic [15:0] sp, input logic [3:0] m);
		return {12'h000, m, sp};
	endfunction : cf
	task automatic t_regs();
		rdc("ctrl", CAL_OFF_CTRL, CAL_RST_CTRL);
		rdc("state", CAL_OFF_STATE, 32'h10);
		rdc("hole", 5'h02, 32'h0);
		wr(CAL_OFF_ALARM2, 32'hFFFFFFFF);
		rdc("cfg2", CAL_OFF_ALARM2, CAL_CFG_MASK);
		// only lane 2 written: option bits cleared, setpoint kept
		avs_byteenable_in <= 4'h4;
		wr(CAL_OFF_ALARM2, 32'h0);
		avs_byteenable_in <= 4'hF;
		rdc("cfg2 lane", CAL_OFF_ALARM2, 32'h0000FFFF);
		wr(CAL_OFF_ALARM2, CAL_RST_CFG);
		$display("done regs");
	endtask : t_regs
	task automatic t_rise();
		wr(CAL_OFF_ALARM1, cf(16'h64, 4'h1));
		samp(32'h65);
		chk("rise", 32'h1, alarm1_relay_out);
		chk("coil1", 32'h1, coil[0]);
		chk("other", 32'h0, alarm2_relay_out);
		samp(32'h64);
		chk("rise eq", 32'h0, alarm1_relay_out);
		$display("done rise");
	endtask : t_rise
	task automatic t_fall();
		wr(CAL_OFF_ALARM2, cf(16'h32, 4'h4));
		samp(32'h33);
		chk("fs idle", 32'h1, alarm2_relay_out);
		chk("coil2", 32'h1, coil[1]);
		samp(32'h31);
		chk("fs trip", 32'h0, alarm2_relay_out);
		wr(CAL_OFF_ALARM2, cf(16'h32, 4'h0));
		tick(2);
		chk("nfs trip", 32'h1, alarm2_relay_out);
		wr(CAL_OFF_ALARM2, CAL_RST_CFG);
		samp(32'h0);
		$display("done fall");
	endtask : t_fall
	task automatic t_latch();
		wr(CAL_OFF_ALARM1, cf(16'h64, 4'h9));
		samp(32'hC8);
		samp(32'h0A);
		chk("held", 32'h1, alarm1_relay_out);
		wr(CAL_OFF_ALARM1, cf(16'h64, 4'hB));
		wr(CAL_OFF_ALARM1, cf(16'h64, 4'h9));
		tick(2);
		chk("defeat clr", 32'h0, alarm1_relay_out);
		samp(32'hC8);
		samp(32'h0A);
		wr(CAL_OFF_ALARM1, cf(16'h64, 4'h1));
		wr(CAL_OFF_ALARM1, cf(16'h64, 4'h9));
		tick(2);
		chk("latch clr", 32'h0, alarm1_relay_out);
		wr(CAL_OFF_ALARM1, cf(16'h64, 4'h3));
		samp(32'hC8);
		chk("defeat", 32'h0, alarm1_relay_out);
		$display("done latch");
	endtask : t_latch
	task automatic t_pct();
		wr(CAL_OFF_CTRL, 32'h1);
		wr(CAL_OFF_ALARM1, cf(16'h1, 4'h1));
		samp(CAL_PPM_PER_PCT);
		chk("pct eq", 32'h0, alarm1_relay_out);
		samp(CAL_PPM_PER_PCT + 32'h1);
		chk("pct hi", 32'h1, alarm1_relay_out);
		rdc("pct st", CAL_OFF_STATE, 32'h35);
		rdc("conc", CAL_OFF_CONC, CAL_PPM_PER_PCT + 32'h1);
		wr(CAL_OFF_CTRL, 32'h0);
		wr(CAL_OFF_ALARM1, cf(16'h64, 4'h1));
		samp(32'h0);
		$display("done pct");
	endtask : t_pct
	task automatic t_irq();
		wr(CAL_OFF_IRQ_CLEAR, 32'h7);
		wr(CAL_OFF_IRQ_ENABLE, 32'h1);
		rdc("irq en", CAL_OFF_IRQ_ENABLE, 32'h1);
		samp(32'hC8);
		chk("irq on", 32'h1, irq_out);
		wr(CAL_OFF_IRQ_CLEAR, 32'h1);
		tick(2);
		chk("irq off", 32'h0, irq_out);
		wr(CAL_OFF_IRQ_ENABLE, 32'h0);
		samp(32'h0);
		samp(32'hC8);
		chk("masked", 32'h0, irq_out);
		rdc("status", CAL_OFF_IRQ_STATUS, 32'h1);
		wr(CAL_OFF_IRQ_CLEAR, 32'h1);
		$display("done irq");
	endtask : t_irq
	task automatic t_sys();
		wr(CAL_OFF_IRQ_ENABLE, 32'h4);
		balance_fail_in <= 1'h1;
		tick(3);
		chk("sys", 32'h0, sys_fail_relay_out);
		chk("coil", 32'h0, coil[2]);
		chk("irq sys", 32'h1, irq_out);
		balance_fail_in <= 1'h0;
		tick(2);
		chk("sys ok", 32'h1, sys_fail_relay_out);
		$display("done sys");
	endtask : t_sys
	task automatic t_reset();
		wr(CAL_OFF_ALARM1, cf(16'h64, 4'h9));
		samp(32'hC8);
		rstn_in <= 1'h0;
		tick(2);
		rstn_in <= 1'h1;
		tick(2);
		chk("rst relay", 32'h0, alarm1_relay_out);
		rdc("rst cfg", CAL_OFF_ALARM1, CAL_RST_CFG);
		chk("rst irq", 32'h0, irq_out);
		// latching again with no new sample must not bring back the old alarm
		wr(CAL_OFF_ALARM1, cf(16'h64, 4'h9));
		tick(2);
		chk("rst latch", 32'h0, alarm1_relay_out);
		$display("done reset");
	endtask : t_reset
	// reset, then every scenario in turn
	initial begin
		clk_in = 1'h0;
		rstn_in = 1'h0;
		avs_address_in = 5'h00;
		avs_read_in = 1'h0;
		avs_write_in = 1'h0;
		avs_byteenable_in = 4'hF;
		avs_writedata_in = 32'h0;
		conc_in = 32'h0;
		conc_valid_in = 1'h0;
		balance_fail_in = 1'h0;
		tick(20);
		rstn_in <= 1'h1;
		tick(1);
		t_regs();
		t_rise();
		t_fall();
		t_latch();
		t_pct();
		t_irq();
		t_sys();
		t_reset();
		give_verdict();
	end
endmodule : concentration_alarm_logic_test
`default_nettype wire
